// ### bdfp_port_logic.sv
`timescale 1ns/10ps
// Summary of operation
// - full fifo ignores further writes
// - read from full frees one, full deasserts
// - read: gate, request, direction high, fifo selected
// - read word appears on output register next
// - drive enables only switch drivers, reads proceed
// - empty fifo refuses reads until written
// - full asserts on filling write, clears on read
// - half flag re-evaluated on each access
// - empty asserts on emptying read, clears on write
// - almost flags, offsets reset eight, programmable
// - almost flags track accesses like full/empty
// - offsets via port A, packed or single
// - two mailboxes, each port writes the other's
// - new-mail flags are status only
// - request sampled, acknowledge registered for gate loopback
// - acknowledge ignores gate
// - ack steady outside almost region, every third inside
// - rewind strobe restarts read pointer, flags update
// - write: gate, request high, direction low, fifo selected
// - reset clears pointers, flags empty, offsets eight
module bdfp_port_logic
    import bdfp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic port_a_gate,
    input wire logic request_a,
    input wire logic direction_a,
    input wire logic [2:0] resource_select_a,
    input wire logic [WORD_W-1:0] data_a_in,
    output logic [WORD_W-1:0] data_a_out,
    output logic data_a_oe,
    input wire logic output_drive_a_n,
    output logic acknowledge_a,
    input wire logic port_b_gate,
    input wire logic request_b,
    input wire logic direction_b,
    input wire logic resource_select_b,
    input wire logic [WORD_W-1:0] data_b_in,
    output logic [WORD_W-1:0] data_b_out,
    output logic data_b_oe,
    input wire logic output_drive_b_n,
    output logic acknowledge_b,
    input wire logic rewind_strobe_1_n,
    input wire logic rewind_strobe_2_n,
    output logic full_flag_1_n,
    output logic half_flag_1_n,
    output logic empty_flag_1_n,
    output logic almost_full_1_n,
    output logic almost_empty_1_n,
    output logic full_flag_2_n,
    output logic half_flag_2_n,
    output logic empty_flag_2_n,
    output logic almost_full_2_n,
    output logic almost_empty_2_n,
    output logic new_mail_flag_1_n,
    output logic new_mail_flag_2_n
);
    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    logic sel_a_fifo, sel_b_fifo, a_fifo, b_fifo;
    logic a_wr_fifo, a_rd_fifo, b_wr_fifo, b_rd_fifo;
    logic a_wr_mbx, a_rd_mbx, b_wr_mbx, b_rd_mbx;
    logic a_ofs, a_wr_ofs, a_rd_ofs;
    logic f1_wr_ok, f1_rd_ok, f2_wr_ok, f2_rd_ok;
    logic [WORD_W-1:0] f1_rd_data, f2_rd_data;
    logic [4:0] f1_flg_n, f2_flg_n;

    assign sel_a_fifo = (resource_select_a == SEL_FIFO);
    assign sel_b_fifo = resource_select_b;
    // the request input acts as a second gate on fifo traffic
    assign a_fifo = port_a_gate && request_a && sel_a_fifo;
    assign b_fifo = port_b_gate && request_b && sel_b_fifo;
    assign a_wr_fifo = a_fifo && !direction_a;
    assign a_rd_fifo = a_fifo && direction_a;
    assign b_wr_fifo = b_fifo && !direction_b;
    assign b_rd_fifo = b_fifo && direction_b;
    // mailbox traffic needs only the gate, not the request
    assign a_wr_mbx = port_a_gate && resource_select_a == SEL_MBOX && !direction_a;
    assign a_rd_mbx = port_a_gate && resource_select_a == SEL_MBOX && direction_a;
    assign b_wr_mbx = port_b_gate && !sel_b_fifo && !direction_b;
    assign b_rd_mbx = port_b_gate && !sel_b_fifo && direction_b;
    // offsets live only behind port A; codes 0..3 single, SEL_OFS_ALL packed
    assign a_ofs = port_a_gate && (!resource_select_a[2] || resource_select_a == SEL_OFS_ALL);
    assign a_wr_ofs = a_ofs && !direction_a;
    assign a_rd_ofs = a_ofs && direction_a;

    // ------------------------------------------------------------
    // flag offset registers: index 3 ae1, 2 af1, 1 ae2, 0 af2
    // ------------------------------------------------------------
    logic [PTR_W-1:0] ofs_reg [0:3];
    logic [PTR_W-1:0] ofs_next [0:3];
    logic [WORD_W-1:0] ofs_word;

    // packed word puts ae1 lowest, each field nine bits wide
    always_comb
    begin
        ofs_word = '0;
        for (int i = 0; i < 4; i++)
        begin
            ofs_next[i] = ofs_reg[i];
            ofs_word[OFS_FIELD*(3-i) +: PTR_W] = ofs_reg[i];
            if (a_wr_ofs && resource_select_a == SEL_OFS_ALL)
                ofs_next[i] = data_a_in[OFS_FIELD*(3-i) +: PTR_W];
            else if (a_wr_ofs && resource_select_a[1:0] == 2'(i))
                ofs_next[i] = data_a_in[PTR_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!rst_b)
                ofs_reg[i] <= OFFSET_RST;
            else if (ce)
                ofs_reg[i] <= ofs_next[i];
        end
    end

    // ------------------------------------------------------------
    // the two fifos: 1 flows a to b, 2 flows b to a
    // ------------------------------------------------------------
    bdfp_fifo_core u_fifo1 (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .wr_en(a_wr_fifo),
        .wr_data(data_a_in),
        .wr_ok(f1_wr_ok),
        .rd_en(b_rd_fifo),
        .rd_ok(f1_rd_ok),
        .rd_data(f1_rd_data),
        .rewind_n(rewind_strobe_1_n),
        .ae_offset(ofs_reg[3]),
        .af_offset(ofs_reg[2]),
        .flags_n(f1_flg_n)
    );

    bdfp_fifo_core u_fifo2 (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .wr_en(b_wr_fifo),
        .wr_data(data_b_in),
        .wr_ok(f2_wr_ok),
        .rd_en(a_rd_fifo),
        .rd_ok(f2_rd_ok),
        .rd_data(f2_rd_data),
        .rewind_n(rewind_strobe_2_n),
        .ae_offset(ofs_reg[1]),
        .af_offset(ofs_reg[0]),
        .flags_n(f2_flg_n)
    );

    assign full_flag_1_n = f1_flg_n[FLG_FULL];
    assign half_flag_1_n = f1_flg_n[FLG_HALF];
    assign empty_flag_1_n = f1_flg_n[FLG_EMPTY];
    assign almost_full_1_n = f1_flg_n[FLG_AFULL];
    assign almost_empty_1_n = f1_flg_n[FLG_AEMPTY];
    assign full_flag_2_n = f2_flg_n[FLG_FULL];
    assign half_flag_2_n = f2_flg_n[FLG_HALF];
    assign empty_flag_2_n = f2_flg_n[FLG_EMPTY];
    assign almost_full_2_n = f2_flg_n[FLG_AFULL];
    assign almost_empty_2_n = f2_flg_n[FLG_AEMPTY];

    // ------------------------------------------------------------
    // mailboxes and new-mail flags
    // ------------------------------------------------------------
    logic [WORD_W-1:0] mbx1_reg, mbx1_next, mbx2_reg, mbx2_next;
    logic mail1_n_reg, mail1_n_next, mail2_n_reg, mail2_n_next;

    // a write sets the flag even when the reader clears it that cycle;
    // the flag never gates the mailbox itself
    always_comb
    begin
        mbx1_next = a_wr_mbx ? data_a_in : mbx1_reg;
        mbx2_next = b_wr_mbx ? data_b_in : mbx2_reg;
        mail1_n_next = a_wr_mbx ? 1'b0 : (b_rd_mbx ? 1'b1 : mail1_n_reg);
        mail2_n_next = b_wr_mbx ? 1'b0 : (a_rd_mbx ? 1'b1 : mail2_n_reg);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            mbx1_reg <= '0;
            mbx2_reg <= '0;
            mail1_n_reg <= 1'b1;
            mail2_n_reg <= 1'b1;
        end
        else if (ce)
        begin
            mbx1_reg <= mbx1_next;
            mbx2_reg <= mbx2_next;
            mail1_n_reg <= mail1_n_next;
            mail2_n_reg <= mail2_n_next;
        end
    end

    assign new_mail_flag_1_n = mail1_n_reg;
    assign new_mail_flag_2_n = mail2_n_reg;

    // ------------------------------------------------------------
    // output registers, drivers switched asynchronously
    // ------------------------------------------------------------
    logic [WORD_W-1:0] out_a_reg, out_a_next, out_b_reg, out_b_next;

    // a read loads the register whatever the drive enable says
    always_comb
    begin
        out_a_next = out_a_reg;
        out_b_next = out_b_reg;
        if (a_rd_fifo && f2_rd_ok)
            out_a_next = f2_rd_data;
        else if (a_rd_mbx)
            out_a_next = mbx2_reg;
        else if (a_rd_ofs && resource_select_a == SEL_OFS_ALL)
            out_a_next = ofs_word;
        else if (a_rd_ofs)
            out_a_next = {28'h0000000, ofs_reg[resource_select_a[1:0]]};
        if (b_rd_fifo && f1_rd_ok)
            out_b_next = f1_rd_data;
        else if (b_rd_mbx)
            out_b_next = mbx1_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            out_a_reg <= '0;
            out_b_reg <= '0;
        end
        else if (ce)
        begin
            out_a_reg <= out_a_next;
            out_b_reg <= out_b_next;
        end
    end

    assign data_a_out = out_a_reg;
    assign data_b_out = out_b_reg;
    assign data_a_oe = !output_drive_a_n;
    assign data_b_oe = !output_drive_b_n;

    // ------------------------------------------------------------
    // request/acknowledge, index 0 port a, 1 port b
    // ------------------------------------------------------------
    logic [1:0] req, dir, blocked, region, ack_reg, ack_next;
    logic [1:0] ph_reg [0:1];
    logic [1:0] ph_next [0:1];

    // boundary view of the fifo each port would touch; the gate is
    // deliberately left out so ack can loop back onto it
    always_comb
    begin
        req = {request_b, request_a};
        dir = {direction_b, direction_a};
        blocked[0] = direction_a ? !f2_flg_n[FLG_EMPTY] : !f1_flg_n[FLG_FULL];
        blocked[1] = direction_b ? !f1_flg_n[FLG_EMPTY] : !f2_flg_n[FLG_FULL];
        region[0] = direction_a ? !f2_flg_n[FLG_AEMPTY] : !f1_flg_n[FLG_AFULL];
        region[1] = direction_b ? !f1_flg_n[FLG_AEMPTY] : !f2_flg_n[FLG_AFULL];
        for (int p = 0; p < 2; p++)
        begin
            ph_next[p] = 2'h0;
            if (req[p] && region[p] && ph_reg[p] != ACK_PHASE_LAST)
                ph_next[p] = ph_reg[p] + 2'h1;
            // inside the almost region only every third cycle acks
            ack_next[p] = req[p] && !blocked[p] &&
                (!region[p] || ph_reg[p] == ACK_PHASE_LAST);
        end
    end

    always_ff @(posedge clk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (!rst_b)
            begin
                ph_reg[p] <= 2'h0;
                ack_reg[p] <= 1'b0;
            end
            else if (ce)
            begin
                ph_reg[p] <= ph_next[p];
                ack_reg[p] <= ack_next[p];
            end
        end
    end

    assign acknowledge_a = ack_reg[0];
    assign acknowledge_b = ack_reg[1];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    ack_full_withheld_a: assert property (
        ce && request_a && !direction_a && !full_flag_1_n |=> !acknowledge_a)
        else $error("ack given into a full fifo");
    ack_third_cycle_a: assert property (
        ce && request_a && !direction_a && !almost_full_1_n && acknowledge_a
        ##1 ce && request_a && !direction_a && !almost_full_1_n |-> !acknowledge_a)
        else $error("ack repeated inside almost full region");
    ack_steady_a: assert property (
        ce && request_b && direction_b && almost_empty_1_n |=> acknowledge_b)
        else $error("ack missing outside almost empty region");
    mail_flag_set_a: assert property (
        ce && a_wr_mbx |=> !new_mail_flag_1_n && data_b_out == $past(data_b_out) || $past(b_rd_mbx))
        else $error("new mail flag not set by mailbox write");
    read_drivers_off_a: assert property (
        ce && a_rd_fifo && f2_rd_ok && output_drive_a_n |=> data_a_out == $past(f2_rd_data))
        else $error("read lost while drivers were off");
    offsets_reset_a: assert property (
        $rose(rst_b) |-> ofs_reg[0] == OFFSET_RST && ofs_reg[3] == OFFSET_RST)
        else $error("flag offsets not eight after reset");

    fill_cov: cover property (ce && !full_flag_1_n);
    rewind_cov: cover property (ce && !rewind_strobe_2_n ##1 ce && a_rd_fifo && f2_rd_ok);
    ack_pulse_cov: cover property (!almost_full_1_n && acknowledge_a ##3 acknowledge_a);
    mail_cov: cover property (ce && a_wr_mbx ##[1:20] ce && b_rd_mbx);
endmodule : bdfp_port_logic

// ### bdfp_pkg.sv
package bdfp_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int WORD_W = 36;
    localparam int DEPTH = 256;
    localparam int PTR_W = 8;
    localparam int CNT_W = 9;
    localparam logic [8:0] DEPTH_CNT = 9'h100;
    localparam logic [8:0] HALF_LEVEL = 9'h081;
    localparam logic [7:0] OFFSET_RST = 8'h08;
    localparam int OFS_FIELD = 9;
    // ------------------------------------------------------------
    // port A resource select codes
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_FIFO = 3'h7;
    localparam logic [2:0] SEL_MBOX = 3'h6;
    localparam logic [2:0] SEL_OFS_ALL = 3'h5;
    localparam logic [2:0] SEL_CTRL = 3'h4;
    // ------------------------------------------------------------
    // flag vector layout and reset, all flags active low
    // ------------------------------------------------------------
    localparam int FLG_FULL = 0;
    localparam int FLG_HALF = 1;
    localparam int FLG_EMPTY = 2;
    localparam int FLG_AFULL = 3;
    localparam int FLG_AEMPTY = 4;
    localparam logic [4:0] FLG_RST = 5'h0B;
    localparam logic [1:0] ACK_PHASE_LAST = 2'h2;
endpackage : bdfp_pkg

// ### bdfp_fifo_core.sv
`timescale 1ns/10ps
module bdfp_fifo_core
    import bdfp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [WORD_W-1:0] wr_data,
    output logic wr_ok,
    input wire logic rd_en,
    output logic rd_ok,
    output logic [WORD_W-1:0] rd_data,
    input wire logic rewind_n,
    input wire logic [PTR_W-1:0] ae_offset,
    input wire logic [PTR_W-1:0] af_offset,
    output logic [4:0] flags_n
);
    logic [WORD_W-1:0] mem [0:DEPTH-1];
    logic [PTR_W-1:0] wptr_reg, wptr_next, fptr_reg, fptr_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [1:0] bc_reg, bc_next, avail;
    logic [WORD_W-1:0] buf0_reg, buf0_next, buf1_reg, buf1_next;
    logic [4:0] flg_reg, flg_next;
    logic wr_do, rd_do, fetch;

    // ------------------------------------------------------------
    // lockout: full refuses writes, empty buffer refuses reads
    // ------------------------------------------------------------
    assign wr_ok = rewind_n && (cnt_reg != DEPTH_CNT);
    assign rd_ok = rewind_n && (bc_reg != 2'h0);
    assign wr_do = wr_en && wr_ok;
    assign rd_do = rd_en && rd_ok;
    assign rd_data = buf0_reg;
    assign flags_n = flg_reg;

    // two-entry read buffer; fetch stalls while it is full and waits for the registered
    // count, which gives the first-read latency after a write into an empty fifo
    always_comb
    begin
        wptr_next = wptr_reg;
        fptr_next = fptr_reg;
        cnt_next = cnt_reg;
        buf0_next = buf0_reg;
        buf1_next = buf1_reg;
        avail = bc_reg - 2'(rd_do);
        fetch = (cnt_reg > CNT_W'(bc_reg)) && (avail != 2'h2);
        if (!rewind_n)
        begin
            // rewind: read side restarts at location zero
            fptr_next = '0;
            bc_next = 2'h0;
            cnt_next = {1'b0, wptr_reg};
        end
        else
        begin
            if (wr_do)
                wptr_next = wptr_reg + 8'h01;
            cnt_next = cnt_reg + CNT_W'(wr_do) - CNT_W'(rd_do);
            if (rd_do)
                buf0_next = buf1_reg;
            if (fetch)
            begin
                if (avail == 2'h0)
                    buf0_next = mem[fptr_reg];
                else
                    buf1_next = mem[fptr_reg];
                fptr_next = fptr_reg + 8'h01;
            end
            bc_next = avail + 2'(fetch);
        end
    end

    // flags follow the new count, re-evaluated on every access
    always_comb
    begin
        flg_next[FLG_FULL] = (cnt_next != DEPTH_CNT);
        flg_next[FLG_HALF] = (cnt_next < HALF_LEVEL);
        flg_next[FLG_EMPTY] = (cnt_next != 9'h000);
        flg_next[FLG_AFULL] = ((DEPTH_CNT - cnt_next) > {1'b0, af_offset});
        flg_next[FLG_AEMPTY] = (cnt_next > {1'b0, ae_offset});
    end

    // state registers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wptr_reg <= '0;
            fptr_reg <= '0;
            cnt_reg <= '0;
            bc_reg <= 2'h0;
            buf0_reg <= '0;
            buf1_reg <= '0;
            flg_reg <= FLG_RST;
        end
        else if (ce)
        begin
            wptr_reg <= wptr_next;
            fptr_reg <= fptr_next;
            cnt_reg <= cnt_next;
            bc_reg <= bc_next;
            buf0_reg <= buf0_next;
            buf1_reg <= buf1_next;
            flg_reg <= flg_next;
        end
    end

    // storage array, no reset needed
    always_ff @(posedge clk)
    begin
        if (ce && wr_do)
            mem[wptr_reg] <= wr_data;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    full_write_ignored_a: assert property (
        ce && rewind_n && wr_en && !rd_en && cnt_reg == DEPTH_CNT
        |=> cnt_reg == DEPTH_CNT && $stable(wptr_reg))
        else $error("write into full fifo was taken");
    read_frees_full_a: assert property (
        ce && rd_do && cnt_reg == DEPTH_CNT |=> flg_reg[FLG_FULL] && cnt_reg == 9'h0FF)
        else $error("read from full fifo did not free a location");
    full_flag_set_a: assert property (
        ce && wr_do && !rd_do && cnt_reg == 9'h0FF |=> !flg_reg[FLG_FULL])
        else $error("full flag not set by filling write");
    empty_flag_set_a: assert property (
        ce && rd_do && !wr_do && cnt_reg == 9'h001 |=> !flg_reg[FLG_EMPTY] ##1 !rd_ok)
        else $error("empty flag or lockout wrong after last read");
    rewind_pointer_a: assert property (
        ce && !rewind_n |=> fptr_reg == 8'h00 && bc_reg == 2'h0 && $stable(wptr_reg))
        else $error("rewind did not restart the read side");
endmodule : bdfp_fifo_core

// ### bdfp_far_end.sv
`timescale 1ns/10ps
module bdfp_far_end
    import bdfp_pkg::*;
(
    input wire logic clk,
    input wire logic hide,
    output logic port_b_gate,
    output logic request_b,
    output logic direction_b,
    output logic resource_select_b,
    output logic [WORD_W-1:0] data_b_in,
    output logic output_drive_b_n
);
    // ------------------------------------------------------------
    // port b host, slowed down by gap idle cycles per access
    // ------------------------------------------------------------
    int gap = 0;
    assign output_drive_b_n = hide;
    initial
    begin
        port_b_gate = 1'b0;
        request_b = 1'b0;
        direction_b = 1'b1;
        resource_select_b = 1'b1;
        data_b_in = 36'h0;
    end
    // controls move only while clk is low
    task b_op(input logic sel, input logic dir, input logic [WORD_W-1:0] d);
        repeat (gap + 1) @(negedge clk);
        port_b_gate = 1'b1;
        request_b = sel; // fifo access needs request
        direction_b = dir;
        resource_select_b = sel;
        data_b_in = d;
        @(negedge clk);
        port_b_gate = 1'b0;
        request_b = 1'b0;
        data_b_in = ~d; // a released bus must not keep the last word
    endtask : b_op
endmodule : bdfp_far_end

// ### bidir_dual_fifo_port_logic_tb_top.sv
`timescale 1ns/10ps
module bidir_dual_fifo_port_logic_tb_top
    import bdfp_pkg::*;
;
    typedef struct packed {logic [2:0] sel; logic [35:0] wr; logic [35:0] rd;} bdfp_row_t;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, hide = 1'b0, output_drive_a_n = 1'b0;
    logic port_a_gate = 1'b0, request_a = 1'b0, direction_a = 1'b0;
    logic rewind_strobe_1_n = 1'b1, rewind_strobe_2_n = 1'b1;
    logic [2:0] resource_select_a = SEL_FIFO;
    logic [WORD_W-1:0] data_a_in = 36'h0, data_a_out, data_b_out, data_b_in;
    logic data_a_oe, data_b_oe, acknowledge_a, acknowledge_b, output_drive_b_n;
    logic port_b_gate, request_b, direction_b, resource_select_b;
    logic full_flag_1_n, half_flag_1_n, empty_flag_1_n, almost_full_1_n, almost_empty_1_n;
    logic full_flag_2_n, half_flag_2_n, empty_flag_2_n, almost_full_2_n, almost_empty_2_n;
    logic new_mail_flag_1_n, new_mail_flag_2_n;
    int failures = 0, samples_checked = 0, cycles = 0;
    // offset rows: written value, value read back over port a
    bdfp_row_t rows [5] = '{
        '{3'h3, 36'hF_FFFF_FF05, 36'h0_0000_0005},
        '{3'h2, 36'h0_0000_00FF, 36'h0_0000_00FF},
        '{3'h1, 36'h0_0000_0111, 36'h0_0000_0011},
        '{3'h0, 36'h0_0000_0022, 36'h0_0000_0022},
        '{3'h5, 36'h8_4422_1108, 36'h0_4020_1008}};

    bdfp_port_logic uut (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .port_a_gate(port_a_gate),
        .request_a(request_a),
        .direction_a(direction_a),
        .resource_select_a(resource_select_a),
        .data_a_in(data_a_in),
        .data_a_out(data_a_out),
        .data_a_oe(data_a_oe),
        .output_drive_a_n(output_drive_a_n),
        .acknowledge_a(acknowledge_a),
        .port_b_gate(port_b_gate),
        .request_b(request_b),
        .direction_b(direction_b),
        .resource_select_b(resource_select_b),
        .data_b_in(data_b_in),
        .data_b_out(data_b_out),
        .data_b_oe(data_b_oe),
        .output_drive_b_n(output_drive_b_n),
        .acknowledge_b(acknowledge_b),
        .rewind_strobe_1_n(rewind_strobe_1_n),
        .rewind_strobe_2_n(rewind_strobe_2_n),
        .full_flag_1_n(full_flag_1_n),
        .half_flag_1_n(half_flag_1_n),
        .empty_flag_1_n(empty_flag_1_n),
        .almost_full_1_n(almost_full_1_n),
        .almost_empty_1_n(almost_empty_1_n),
        .full_flag_2_n(full_flag_2_n),
        .half_flag_2_n(half_flag_2_n),
        .empty_flag_2_n(empty_flag_2_n),
        .almost_full_2_n(almost_full_2_n),
        .almost_empty_2_n(almost_empty_2_n),
        .new_mail_flag_1_n(new_mail_flag_1_n),
        .new_mail_flag_2_n(new_mail_flag_2_n)
    );

    bdfp_far_end u_far (
        .clk(clk),
        .hide(hide),
        .port_b_gate(port_b_gate),
        .request_b(request_b),
        .direction_b(direction_b),
        .resource_select_b(resource_select_b),
        .data_b_in(data_b_in),
        .output_drive_b_n(output_drive_b_n)
    );

    // ------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------
    always #5 clk = ~clk;

    // a hang counts as a mismatch and still ends in the one report
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            report_and_stop();
        end
    end

    task check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task report_and_stop;
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // port a host; the idle cycle first keeps both latencies
    task a_op(input logic [2:0] sel, input logic dir, input logic [WORD_W-1:0] d);
        @(negedge clk);
        port_a_gate = 1'b1;
        request_a = (sel == SEL_FIFO);
        direction_a = dir;
        resource_select_a = sel;
        data_a_in = d;
        @(negedge clk);
        port_a_gate = 1'b0;
        request_a = 1'b0;
    endtask : a_op

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        check(36'(empty_flag_1_n), 36'h0);
        check(36'(almost_full_2_n), 36'h1);
        check(36'(new_mail_flag_2_n), 36'h1);
        foreach (rows[i])
        begin
            a_op(rows[i].sel, 1'b0, rows[i].wr);
            a_op(rows[i].sel, 1'b1, 36'h0);
            check(data_a_out, rows[i].rd);
        end
        // one word a to b, then a read of the drained fifo is refused
        a_op(SEL_FIFO, 1'b0, 36'hA_5A5A_5A5A);
        check(36'(empty_flag_1_n), 36'h1);
        u_far.b_op(1'b1, 1'b1, 36'h0);
        check(data_b_out, 36'hA_5A5A_5A5A);
        check(36'(empty_flag_1_n), 36'h0);
        u_far.b_op(1'b1, 1'b1, 36'h0);
        check(data_b_out, 36'hA_5A5A_5A5A);
        // mailbox a to b, then a write under a frozen clock enable
        a_op(SEL_MBOX, 1'b0, 36'h1_2345_6789);
        check(36'(new_mail_flag_1_n), 36'h0);
        u_far.b_op(1'b0, 1'b1, 36'h0);
        check(data_b_out, 36'h1_2345_6789);
        check(36'(new_mail_flag_1_n), 36'h1);
        ce = 1'b0;
        a_op(SEL_MBOX, 1'b0, 36'h0_0000_0001);
        ce = 1'b1;
        check(36'(new_mail_flag_1_n), 36'h1);
        // b to a with port a drivers off: the read still lands
        u_far.b_op(1'b1, 1'b0, 36'h3_C3C3_C3C3);
        output_drive_a_n = 1'b1;
        a_op(SEL_FIFO, 1'b1, 36'h0);
        check(36'(data_a_oe), 36'h0);
        output_drive_a_n = 1'b0;
        #1;
        check(data_a_out, 36'h3_C3C3_C3C3);
        check(36'(data_a_oe), 36'h1);
        // acknowledge with the gate low
        @(negedge clk);
        request_a = 1'b1;
        direction_a = 1'b0;
        resource_select_a = SEL_FIFO;
        @(negedge clk);
        check(36'(acknowledge_a), 36'h1);
        request_a = 1'b0;
        @(negedge clk);
        check(36'(acknowledge_a), 36'h0);
        // fill fifo 1 back to back; the 257th write must be refused
        port_a_gate = 1'b1;
        request_a = 1'b1;
        data_a_in = 36'h1;
        repeat (256)
        begin
            @(negedge clk);
            data_a_in = data_a_in + 36'h1;
        end
        check(36'(full_flag_1_n), 36'h0);
        check(36'(half_flag_1_n), 36'h0);
        check(36'(almost_full_1_n), 36'h0);
        @(negedge clk);
        port_a_gate = 1'b0;
        request_a = 1'b0;
        u_far.b_op(1'b1, 1'b1, 36'h0);
        check(data_b_out, 36'h1);
        check(36'(full_flag_1_n), 36'h1);
        // rewind: location zero holds the last fill word
        @(negedge clk);
        rewind_strobe_1_n = 1'b0;
        @(negedge clk);
        rewind_strobe_1_n = 1'b1;
        u_far.b_op(1'b1, 1'b1, 36'h0);
        check(data_b_out, 36'h100);
        check(36'(empty_flag_1_n), 36'h0);
        // second reset in mid-run
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        check(36'(empty_flag_2_n), 36'h0);
        check(data_b_out, 36'h0);
        a_op(SEL_OFS_ALL, 1'b1, 36'h0);
        check(data_a_out, 36'h0_4020_1008);
        report_and_stop();
    end
endmodule : bidir_dual_fifo_port_logic_tb_top
